// ---- src/bridge_pwr_consts.svh ----
// timing and encoding constants for the bridge reset and power sequencer
`ifndef BRIDGE_PWR_CONSTS_SVH
`define BRIDGE_PWR_CONSTS_SVH
`define CLK_PERIOD_PS            32'd4000
`define CLK_PERIOD_NS            32'd4
`define POWER_TO_RESET_MS        32'd100
`define CLOCK_TO_RESET_US        32'd100
`define RAIL_FAIL_TO_RESET_NS    32'd500
`define RESET_ACTIVE_US          32'd100
`define CLK_HOLD_US              32'd100
`define POWER_TO_RESET_CYC  ((`POWER_TO_RESET_MS * 32'd1000000 + \
  `CLK_PERIOD_NS - 32'd1) / `CLK_PERIOD_NS)
`define CLOCK_TO_RESET_CYC  ((`CLOCK_TO_RESET_US * 32'd1000000 + \
  `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define RAIL_FAIL_CYC       ((`RAIL_FAIL_TO_RESET_NS * 32'd1000) / \
  `CLK_PERIOD_PS)
`define CLK_HOLD_CYC        ((`CLK_HOLD_US * 32'd1000000 + \
  `CLK_PERIOD_PS - 32'd1) / `CLK_PERIOD_PS)
`define PCIE_START_CYC           8'h10
`define DSTATE_D0                2'h0
`define DSTATE_D1                2'h1
`define DSTATE_D2                2'h2
`define DSTATE_D3HOT             2'h3
`endif

// ---- src/bridge_pwr_dev.sv ----
// bridge device end: reset synchronising, power states, event translation
`timescale 1ns/1ps
`include "bridge_pwr_consts.svh"
module bridge_pwr_dev
  import bridge_pwr_pkg::*;
(
  input  wire logic          sys_clk,
  input  wire logic          reset,
  input  wire logic          reverseMode,
  input  wire logic          dstateWr,
  input  wire logic [1:0]    dstateWrData,
  input  wire logic          stickyWr,
  input  wire logic [7:0]    stickyWrData,
  input  wire logic          pmMsgRx,
  input  wire logic          pmEventAck,
  input  wire logic          linkIdle,
  input  wire logic          linkExitReq,
  input  wire logic          enterL1Req,
  input  wire logic          enterL23Req,
  input  wire logic          wakeReq,
  output logic               linkReset,
  output logic               pmMsgTx,
  output logic [1:0]         dstate,
  output logic               dstateReject,
  output logic [1:0]         busState,
  output logic [2:0]         linkState,
  output logic [7:0]         stickyOut,
  bridge_pwr_if.device       lnk
);
  logic         rstMeta_r;
  logic         rstSync_r;
  logic [7:0]   startCnt_r;
  logic         pinMeta_r;
  logic         pinSync_r;
  logic         pinPrev_r;
  logic         pinDrive_r;
  logic         beacon_r;
  link_pstate_t lstate_r;
  bus_pstate_t  bstate_r;
  logic         held;

  function automatic logic dstate_ok(input logic [1:0] d);
    dstate_ok = (d == `DSTATE_D0) || (d == `DSTATE_D3HOT);
  endfunction

  function automatic bus_pstate_t bus_for(input logic [1:0] d,
                                          input logic       off);
    if (off)
      bus_for = BUS_B3;
    else if (d == `DSTATE_D3HOT)
      bus_for = BUS_B2;
    else
      bus_for = BUS_B0;
  endfunction

  // two-stage synchroniser for the asynchronous fundamental reset
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      rstMeta_r <= 1'b0;
      rstSync_r <= 1'b0;
    end
    else
    begin
      rstMeta_r <= lnk.fundResetN;
      rstSync_r <= rstMeta_r;
    end
  end

  assign held = ~rstSync_r || (startCnt_r != `PCIE_START_CYC);

  // link functions start only a short count after release
  always_ff @(posedge sys_clk)
  begin
    if (reset || !rstSync_r)
    begin
      startCnt_r <= 8'h0;
      linkReset  <= 1'b1;
    end
    else
    begin
      if (startCnt_r != `PCIE_START_CYC)
        startCnt_r <= startCnt_r + 8'h1;
      linkReset <= held;
    end
  end

  // sticky state: cleared by sys reset only (aux power), not fundamental
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      stickyOut <= 8'h0;
    else if (stickyWr)
      stickyOut <= stickyWrData;
  end

  // device power state; D1 and D2 writes are refused
  always_ff @(posedge sys_clk)
  begin
    if (reset || held)
    begin
      dstate       <= `DSTATE_D0;
      dstateReject <= 1'b0;
    end
    else
    begin
      dstateReject <= dstateWr && !dstate_ok(dstateWrData);
      if (dstateWr && dstate_ok(dstateWrData))
        dstate <= dstateWrData;
    end
  end

  // bus power state follows device state, B3 when main power gone
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      bstate_r <= BUS_B3;
    else
      bstate_r <= bus_for(dstate, held);
  end
  assign busState = bstate_r;

  // link power state machine with active-state entry to L0s
  always_ff @(posedge sys_clk)
  begin
    if (reset || held)
      lstate_r <= LINK_L3;
    else
    begin
      case (lstate_r)
        LINK_L0:
          if (enterL23Req)
            lstate_r <= LINK_L23RDY;
          else if (enterL1Req || dstate == `DSTATE_D3HOT)
            lstate_r <= LINK_L1;
          else if (linkIdle)
            lstate_r <= LINK_L0S;
        LINK_L0S:
          if (!linkIdle || linkExitReq)
            lstate_r <= LINK_L0;
        LINK_L1:
          if (linkExitReq || wakeReq)
            lstate_r <= LINK_L0;
        LINK_L23RDY:
          if (linkExitReq)
            lstate_r <= LINK_L0;
        LINK_L3:
          lstate_r <= LINK_L0;
        default:
          lstate_r <= LINK_L3;
      endcase
    end
  end
  assign linkState = lstate_r;

  // beacon while in a low link state and wakeup wanted
  always_ff @(posedge sys_clk)
  begin
    if (reset)
      beacon_r <= 1'b0;
    else
      beacon_r <= wakeReq && (lstate_r == LINK_L1 ||
                              lstate_r == LINK_L23RDY);
  end
  assign lnk.beacon = beacon_r;

  // event pin sampling for forward mode
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      pinMeta_r <= 1'b1;
      pinSync_r <= 1'b1;
      pinPrev_r <= 1'b1;
    end
    else
    begin
      pinMeta_r <= lnk.pmEventPinIn;
      pinSync_r <= pinMeta_r;
      pinPrev_r <= pinSync_r;
    end
  end

  // forward: falling edge of pin becomes one upstream message
  always_ff @(posedge sys_clk)
  begin
    if (reset || held)
      pmMsgTx <= 1'b0;
    else
      pmMsgTx <= !reverseMode && pinPrev_r && !pinSync_r;
  end

  // reverse: message drives pin low until acknowledged; set wins
  always_ff @(posedge sys_clk)
  begin
    if (reset || held || !reverseMode)
      pinDrive_r <= 1'b0;
    else if (pmMsgRx)
      pinDrive_r <= 1'b1;
    else if (pmEventAck)
      pinDrive_r <= 1'b0;
  end
  assign lnk.pmEventPinOut = 1'b0;
  assign lnk.pmEventPinOe  = ~pinDrive_r;
endmodule

// ---- src/bridge_pwr_if.sv ----
// link between platform power controller and the bridge device
`timescale 1ns/1ps
interface bridge_pwr_if;
  logic fundResetN;
  logic refClkRun;
  logic pmEventPinOut;
  logic pmEventPinOe;
  logic pmEventPinIn;
  logic beacon;
  modport device (input fundResetN, input refClkRun, output pmEventPinOut,
                  output pmEventPinOe, input pmEventPinIn, output beacon);
  modport platform (output fundResetN, output refClkRun,
                    input beacon);
endinterface

// ---- src/bridge_pwr_pkg.sv ----
// types shared by both ends of the reset and power link
package bridge_pwr_pkg;
  typedef enum logic [1:0] {BUS_B0, BUS_B1, BUS_B2, BUS_B3} bus_pstate_t;
  typedef enum logic [2:0] {LINK_L0, LINK_L0S, LINK_L1, LINK_L23RDY,
                            LINK_L3} link_pstate_t;
  typedef logic [1:0] dstate_t;
endpackage

// ---- src/platform_pwr_ctrl.sv ----
// platform power and reset controller driving fundamental reset and clock
`timescale 1ns/1ps
`include "bridge_pwr_consts.svh"
module platform_pwr_ctrl
  import bridge_pwr_pkg::*;
#(
  parameter int unsigned POWER_CYC = `POWER_TO_RESET_CYC,
  parameter int unsigned CLKST_CYC = `CLOCK_TO_RESET_CYC,
  parameter int unsigned HOLD_CYC  = `CLK_HOLD_CYC
)(
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic         railsGood,
  input  wire logic         powerOnReq,
  output logic              coreOn,
  output logic              ioOn,
  output logic              linkUp,
  output logic              wakeSeen,
  bridge_pwr_if.platform    lnk
);
  typedef enum logic [2:0] {P_OFF, P_RAMP, P_CLK, P_RUN, P_HOLD,
                            P_DOWN} pstate_t;
  pstate_t     st_r;
  logic [31:0] cnt_r;
  logic        resetN_r;
  logic        clk_r;

  assign lnk.fundResetN = resetN_r;
  assign lnk.refClkRun  = clk_r;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      st_r     <= P_OFF;
      cnt_r    <= 32'h0;
      resetN_r <= 1'b0;
      clk_r    <= 1'b0;
      coreOn   <= 1'b0;
      ioOn     <= 1'b0;
      linkUp   <= 1'b0;
    end
    else if ((st_r == P_CLK || st_r == P_RUN) && !railsGood)
    begin
      // rail failure: reset asserted on the next edge, well inside 500 ns
      resetN_r <= 1'b0;
      linkUp   <= 1'b0;
      st_r     <= P_HOLD;
      cnt_r    <= 32'h0;
    end
    else
    begin
      case (st_r)
        P_OFF:
          if (powerOnReq)
          begin
            ioOn   <= 1'b1;
            coreOn <= 1'b1;
            cnt_r  <= 32'h0;
            st_r   <= P_RAMP;
          end
        P_RAMP:
          if (railsGood)
          begin
            clk_r <= 1'b1;
            cnt_r <= cnt_r + 32'h1;
            if (cnt_r + 32'h1 >= POWER_CYC - CLKST_CYC)
            begin
              cnt_r <= 32'h0;
              st_r  <= P_CLK;
            end
          end
          else
            cnt_r <= 32'h0;
        P_CLK:
        begin
          // power stable 100 ms and clock stable 100 us before release
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r + 32'h1 >= CLKST_CYC)
          begin
            resetN_r <= 1'b1;
            linkUp   <= 1'b1;
            st_r     <= P_RUN;
          end
        end
        P_RUN:
          if (!powerOnReq)
          begin
            resetN_r <= 1'b0;
            linkUp   <= 1'b0;
            cnt_r    <= 32'h0;
            st_r     <= P_HOLD;
          end
        P_HOLD:
        begin
          cnt_r <= cnt_r + 32'h1;
          if (cnt_r + 32'h1 >= HOLD_CYC)
          begin
            clk_r <= 1'b0;
            st_r  <= P_DOWN;
          end
        end
        P_DOWN:
        begin
          // core power drops first, io power the edge after
          coreOn <= 1'b0;
          ioOn   <= ~coreOn ? 1'b0 : ioOn;
          if (!coreOn)
            st_r <= P_OFF;
        end
        default:
          st_r <= P_OFF;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      wakeSeen <= 1'b0;
    else
      wakeSeen <= lnk.beacon;
  end
endmodule

// ---- tb/bridge_pwr_props.sv ----
// assertions on the link between platform controller and bridge device
`timescale 1ns/1ps
module bridge_pwr_props #(
  parameter int unsigned CLKST_CYC = 10,
  parameter int unsigned HOLD_CYC  = 10
)(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic fundResetN,
  input wire logic refClkRun,
  input wire logic pmEventPinOut,
  input wire logic pmEventPinOe,
  input wire logic pmEventPinIn,
  input wire logic beacon
);
  logic [7:0] clkCnt_r;
  logic [7:0] lowCnt_r;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (reset);
  // cycles with clock running, cycles with reset asserted
  always_ff @(posedge sys_clk)
    if (reset || !refClkRun) clkCnt_r <= 8'h00;
    else if (clkCnt_r != 8'hff) clkCnt_r <= clkCnt_r + 8'h01;
  always_ff @(posedge sys_clk)
    if (reset || fundResetN) lowCnt_r <= 8'h00;
    else if (lowCnt_r != 8'hff) lowCnt_r <= lowCnt_r + 8'h01;
  a_pin_open_drain:
    assert property (pmEventPinOut == 1'b0) else $error("pin drives high");
  a_reset_pin_idle:
    assert property ($fell(reset) |-> pmEventPinOe)
    else $error("pin driven after reset");
  a_reset_no_beacon:
    assert property ($fell(reset) |-> !beacon) else $error("beacon at reset");
  a_reset_plat_low:
    assert property ($fell(reset) |-> !fundResetN && !refClkRun)
    else $error("platform outputs not idle");
  a_clk_before_rel:
    assert property ($rose(fundResetN) |-> clkCnt_r >= CLKST_CYC)
    else $error("release before clock stable");
  a_rel_needs_clk:
    assert property (fundResetN |-> refClkRun)
    else $error("released without clock");
  a_stop_after_rst:
    assert property ($fell(refClkRun) |-> !fundResetN)
    else $error("clock stopped before reset");
  a_clk_hold_time:
    assert property ($fell(refClkRun) |-> lowCnt_r >= HOLD_CYC)
    else $error("clock hold too short");
endmodule

// ---- tb/bridge_reset_power_sequencer_test.sv ----
// self-checking bench joining platform controller and bridge device
`timescale 1ns/1ps
module bridge_reset_power_sequencer_test;
  import bridge_pwr_pkg::*;
  localparam int unsigned PW = 40, CK = 10, HD = 10;
  logic       sys_clk, reset, railsGood, powerOnReq, extLow, coreOn, ioOn;
  logic       linkUp, wakeSeen, reverseMode, dstateWr, stickyWr, pmMsgRx;
  logic       pmEventAck, linkIdle, wakeReq, linkReset, pmMsgTx;
  logic       dstateReject;
  logic       linkExitReq, enterL1Req, enterL23Req;
  logic [1:0] dstateWrData, dstate, busState;
  logic [2:0] linkState;
  logic [7:0] stickyWrData, stickyOut;
  int         error_cnt, comparisons, n, k, expD;
  int         q[$];
  bridge_pwr_if ifc();
  // pull-up on the event pin, low when either party pulls it
  assign ifc.pmEventPinIn = ifc.pmEventPinOe & ~extLow;
  platform_pwr_ctrl #(.POWER_CYC(PW), .CLKST_CYC(CK), .HOLD_CYC(HD))
    u_platform_pwr_ctrl (.sys_clk, .reset, .railsGood, .powerOnReq, .coreOn,
    .ioOn, .linkUp, .wakeSeen, .lnk(ifc.platform));
  bridge_pwr_dev u_bridge_pwr_dev (.sys_clk, .reset, .reverseMode, .dstateWr,
    .dstateWrData, .stickyWr, .stickyWrData, .pmMsgRx, .pmEventAck, .linkIdle,
    .linkExitReq, .enterL1Req, .enterL23Req, .wakeReq,
    .linkReset, .pmMsgTx, .dstate, .dstateReject, .busState, .linkState,
    .stickyOut, .lnk(ifc.device));
  bridge_pwr_props #(.CLKST_CYC(CK), .HOLD_CYC(HD)) u_props (.sys_clk,
    .reset, .fundResetN(ifc.fundResetN), .refClkRun(ifc.refClkRun),
    .pmEventPinOut(ifc.pmEventPinOut), .pmEventPinOe(ifc.pmEventPinOe),
    .pmEventPinIn(ifc.pmEventPinIn), .beacon(ifc.beacon));
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic hit(input bit ok);
    if (!ok)
    begin
      error_cnt++;
      $display("[ERR] wait expected 1 seen 0");
      conclude();
    end
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  // device state write; the model keeps the last accepted state
  task automatic wrD(input logic [1:0] d);
    @(posedge sys_clk) dstateWr <= 1'b1;
    dstateWrData <= d;
    @(posedge sys_clk) dstateWr <= 1'b0;
    #1;
    if (d == 2'h0 || d == 2'h3) expD = d;
    chk("reject", {7'h0, d == 2'h1 || d == 2'h2}, {7'h0, dstateReject});
    chk("dstate", 8'(expD), {6'h0, dstate});
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    {reset, railsGood, powerOnReq, extLow, reverseMode, dstateWr} = 6'h20;
    {stickyWr, pmMsgRx, pmEventAck, linkIdle, wakeReq} = 5'h00;
    {linkExitReq, enterL1Req, enterL23Req} = 3'h0;
    dstateWrData = 2'h0;
    stickyWrData = 8'h00;
    n = $urandom(32'h134a7548);
    tick(20);
    @(posedge sys_clk) reset <= 1'b0;
    tick(1);
    chk("linkState", 8'h04, {5'h0, linkState});
    chk("busState", 8'h03, {6'h0, busState});
    @(posedge sys_clk) powerOnReq <= 1'b1;
    railsGood <= 1'b1;
    for (n = 0; n < 200 && ifc.fundResetN !== 1'b1; n++)
    begin
      chk("linkReset", 8'h01, {7'h0, linkReset});
      tick(1);
    end
    hit(n < 200);
    chk("powerHold", 8'h01, {7'h0, n >= PW});
    for (n = 0; n < 40 && linkReset !== 1'b0; n++) tick(1);
    chk("startDelay", 8'h01, {7'h0, n >= 17 && n <= 21});
    tick(2);
    chk("linkState", {5'h0, LINK_L0}, {5'h0, linkState});
    @(posedge sys_clk) linkIdle <= 1'b1;
    tick(2);
    chk("linkState", {5'h0, LINK_L0S}, {5'h0, linkState});
    @(posedge sys_clk) linkIdle <= 1'b0;
    q.push_back($urandom & 8'hff);
    @(posedge sys_clk) stickyWr <= 1'b1;
    stickyWrData <= 8'(q[0]);
    @(posedge sys_clk) stickyWr <= 1'b0;
    tick(1);
    chk("sticky", 8'(q[0]), stickyOut);
    @(posedge sys_clk) enterL1Req <= 1'b1;
    @(posedge sys_clk) enterL1Req <= 1'b0;
    tick(1);
    chk("linkState", {5'h0, LINK_L1}, {5'h0, linkState});
    @(posedge sys_clk) linkExitReq <= 1'b1;
    @(posedge sys_clk) linkExitReq <= 1'b0;
    @(posedge sys_clk) enterL23Req <= 1'b1;
    @(posedge sys_clk) enterL23Req <= 1'b0;
    tick(1);
    chk("linkState", {5'h0, LINK_L23RDY}, {5'h0, linkState});
    @(posedge sys_clk) linkExitReq <= 1'b1;
    @(posedge sys_clk) linkExitReq <= 1'b0;
    tick(1);
    chk("linkState", {5'h0, LINK_L0}, {5'h0, linkState});
    @(posedge sys_clk) extLow <= 1'b1;
    k = 0;
    for (n = 0; n < 6; n++)
    begin
      tick(1);
      k += pmMsgTx;
    end
    chk("pmMsgTx", 8'h01, 8'(k));
    @(posedge sys_clk) extLow <= 1'b0;
    reverseMode <= 1'b1;
    pmMsgRx <= 1'b1;
    @(posedge sys_clk) pmMsgRx <= 1'b0;
    tick(4);
    chk("pinLevel", 8'h00, {7'h0, ifc.pmEventPinIn});
    @(posedge sys_clk) pmEventAck <= 1'b1;
    @(posedge sys_clk) pmEventAck <= 1'b0;
    tick(1);
    chk("pinLevel", 8'h01, {7'h0, ifc.pmEventPinIn});
    for (int i = 0; i < 8; i++) wrD(i < 4 ? 2'(i) : 2'($urandom));
    wrD(2'h3);
    tick(2);
    chk("busState", {6'h0, BUS_B2}, {6'h0, busState});
    chk("linkState", {5'h0, LINK_L1}, {5'h0, linkState});
    @(posedge sys_clk) wakeReq <= 1'b1;
    tick(1);
    chk("beacon", 8'h01, {7'h0, ifc.beacon});
    tick(1);
    chk("wakeSeen", 8'h01, {7'h0, wakeSeen});
    @(posedge sys_clk) wakeReq <= 1'b0;
    powerOnReq <= 1'b0;
    for (n = 0; n < 100 && ioOn !== 1'b0; n++) tick(1);
    hit(n < 100);
    tick(3);
    chk("linkReset", 8'h01, {7'h0, linkReset});
    chk("sticky", 8'(q[0]), stickyOut);
    @(posedge sys_clk) powerOnReq <= 1'b1;
    for (n = 0; n < 200 && linkReset !== 1'b0; n++) tick(1);
    hit(n < 200);
    chk("sticky", 8'(q[0]), stickyOut);
    @(posedge sys_clk) railsGood <= 1'b0;
    tick(1);
    chk("railFail", 8'h00, {7'h0, ifc.fundResetN});
    @(posedge sys_clk) powerOnReq <= 1'b0;
    for (n = 0; n < 100 && ioOn !== 1'b0; n++) tick(1);
    hit(n < 100);
    chk("linkReset", 8'h01, {7'h0, linkReset});
    conclude();
  end
endmodule
